// [flash_seq_regs.vh]
// Constants for the flash program, erase and lock sequencer host controller
`ifndef FLASH_SEQ_REGS_VH
`define FLASH_SEQ_REGS_VH
`define CMD_READ_ARRAY   8'hFF
`define CMD_READ_STATUS  8'h70
`define CMD_CLEAR_STATUS 8'h50
`define CMD_PROGRAM      8'h40
`define CMD_PROGRAM_ALT  8'h10
`define CMD_CHIP_ERASE   8'h30
`define CMD_ERASE_CONF   8'hD0
`define CMD_LOCK_SETUP   8'h60
`define CMD_LOCK_BLOCK   8'h01
`define CMD_LOCK_PERM    8'hF1
`define CMD_OTP_SETUP    8'hC0
`define SR_READY         7
`define SR_ERASE_ERR     5
`define SR_PROG_ERR      4
`define SR_SUPPLY_LOW    3
`define SR_PROTECT       1
`define SR_ERROR_MASK    8'h3A
// Host registers, word index
`define REG_CTRL   4'h0
`define REG_ADDR   4'h1
`define REG_DATA   4'h2
`define REG_STATUS 4'h3
`define REG_RESULT 4'h4
// Operation codes written to REG_CTRL[2:0]; bit 3 selects program alternate
`define OP_PROGRAM    3'h1
`define OP_CHIP_ERASE 3'h2
`define OP_LOCK_BLOCK 3'h3
`define OP_LOCK_PERM  3'h4
`define OP_UNLOCK     3'h5
`define OP_OTP        3'h6
`define OP_CLEAR      3'h7
`define CTRL_ALT_BIT  3
`define CTRL_ARRAY_BIT 4
// Bus write cycle shape in clocks: setup, strobe low, hold
`define WR_SETUP  3'h1
`define WR_PULSE  3'h3
`define WR_HOLD   3'h1
`define RD_ACCESS 3'h4
`define ADDR_W    21
`endif

// [flash_bus_cycle.v]
// One asynchronous write or read cycle on the flash pins
`timescale 1ns/10ps
`include "flash_seq_regs.vh"
module flash_bus_cycle (
   input  wire                 clock,
   input  wire                 rst_sync_b,
   input  wire                 start,
   input  wire                 is_write,
   input  wire [`ADDR_W-1:0]   addr,
   input  wire [15:0]          wdata,
   input  wire [15:0]          dq_sync,
   output reg                  done,
   output reg  [15:0]          rdata,
   output reg  [`ADDR_W-1:0]   flash_addr,
   output reg  [15:0]          dq_out,
   output reg                  dq_oe_b,
   output reg                  ce_b,
   output reg                  we_b,
   output reg                  oe_b
);
   localparam S_IDLE  = 4'b0001;
   localparam S_SETUP = 4'b0010;
   localparam S_PULSE = 4'b0100;
   localparam S_HOLD  = 4'b1000;
   reg [3:0] state;
   reg [2:0] count;
   reg       wr;
   always @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         state <= S_IDLE;
         count <= 3'h0;
         wr <= 1'b0;
         done <= 1'b0;
         rdata <= 16'h0000;
         flash_addr <= {`ADDR_W{1'b0}};
         dq_out <= 16'h0000;
         dq_oe_b <= 1'b1;
         ce_b <= 1'b1;
         we_b <= 1'b1;
         oe_b <= 1'b1;
      end else begin
         done <= 1'b0;
         case (state)
            S_IDLE: begin
               if (start) begin
                  wr <= is_write;
                  flash_addr <= addr;
                  dq_out <= wdata;
                  dq_oe_b <= ~is_write;
                  ce_b <= 1'b0;
                  count <= `WR_SETUP;
                  state <= S_SETUP;
               end
            end
            S_SETUP: begin
               if (count == 3'h1) begin
                  we_b <= ~wr;
                  oe_b <= wr;
                  count <= wr ? `WR_PULSE : `RD_ACCESS;
                  state <= S_PULSE;
               end else
                  count <= count - 3'h1;
            end
            S_PULSE: begin
               // Read data is taken through the synchroniser, so access time covers four clocks
               if (count == 3'h1) begin
                  if (!wr)
                     rdata <= dq_sync;
                  we_b <= 1'b1;
                  oe_b <= 1'b1;
                  count <= `WR_HOLD;
                  state <= S_HOLD;
               end else
                  count <= count - 3'h1;
            end
            S_HOLD: begin
               if (count == 3'h1) begin
                  ce_b <= 1'b1;
                  dq_oe_b <= 1'b1;
                  done <= 1'b1;
                  state <= S_IDLE;
               end else
                  count <= count - 3'h1;
            end
            default: state <= S_IDLE;
         endcase
      end
   end
endmodule // flash_bus_cycle

// [flash_program_erase_lock_sequencer.v]
// Host controller that sequences program, erase and lock commands into the flash
`timescale 1ns/10ps
`include "flash_seq_regs.vh"
module flash_program_erase_lock_sequencer (
   input  wire                 clock,
   input  wire                 rst_b,
   input  wire [3:0]           reg_addr,
   input  wire [31:0]          reg_wdata,
   input  wire                 reg_write,
   input  wire                 reg_read,
   output reg  [31:0]          reg_rdata,
   output reg  [`ADDR_W-1:0]   flash_addr,
   output reg  [15:0]          dq_out,
   output reg                  dq_oe_b,
   input  wire [15:0]          dq_in,
   output reg                  ce_b,
   output reg                  we_b,
   output reg                  oe_b,
   output reg                  flash_reset_b,
   input  wire                 ready_busy_output
);
   localparam S_IDLE   = 8'b00000001;
   localparam S_SETUP  = 8'b00000010;
   localparam S_SECOND = 8'b00000100;
   localparam S_POLLC  = 8'b00001000;
   localparam S_POLLR  = 8'b00010000;
   localparam S_ARRAY  = 8'b00100000;
   localparam S_WAIT   = 8'b01000000;
   localparam S_CLEAR  = 8'b10000000;

   reg              rst_meta_b;
   reg              rst_sync_b;
   reg [15:0]       dq_meta;
   reg [15:0]       dq_sync;
   reg              rb_meta;
   reg              rb_sync;
   reg [7:0]        state;
   reg [7:0]        next_state;
   reg [2:0]        op;
   reg              alt;
   reg              array_after;
   reg [`ADDR_W-1:0] op_addr;
   reg [15:0]       op_data;
   reg [7:0]        last_status;
   reg              busy;
   reg              error;
   reg              start;
   reg              is_write;
   reg [`ADDR_W-1:0] cyc_addr;
   reg [15:0]       cyc_data;
   wire             cyc_done;
   wire [15:0]      cyc_rdata;
   wire [`ADDR_W-1:0] pin_addr;
   wire [15:0]      pin_dq;
   wire             pin_dq_oe_b;
   wire             pin_ce_b;
   wire             pin_we_b;
   wire             pin_oe_b;

   // Setup command for each operation
   function [7:0] setup_code;
      input [2:0] o;
      input       a;
      begin
         case (o)
            `OP_PROGRAM:    setup_code = a ? `CMD_PROGRAM_ALT : `CMD_PROGRAM;
            `OP_CHIP_ERASE: setup_code = `CMD_CHIP_ERASE;
            `OP_LOCK_BLOCK: setup_code = `CMD_LOCK_SETUP;
            `OP_LOCK_PERM:  setup_code = `CMD_LOCK_SETUP;
            `OP_UNLOCK:     setup_code = `CMD_LOCK_SETUP;
            `OP_OTP:        setup_code = `CMD_OTP_SETUP;
            `OP_CLEAR:      setup_code = `CMD_CLEAR_STATUS;
            default:        setup_code = `CMD_READ_ARRAY;
         endcase
      end
   endfunction

   // Second write: data at target for program and OTP, confirm code otherwise
   function [15:0] second_code;
      input [2:0]  o;
      input [15:0] d;
      begin
         case (o)
            `OP_PROGRAM:    second_code = d;
            `OP_OTP:        second_code = d;
            `OP_CHIP_ERASE: second_code = {8'h00, `CMD_ERASE_CONF};
            `OP_LOCK_BLOCK: second_code = {8'h00, `CMD_LOCK_BLOCK};
            `OP_LOCK_PERM:  second_code = {8'h00, `CMD_LOCK_PERM};
            `OP_UNLOCK:     second_code = {8'h00, `CMD_ERASE_CONF};
            default:        second_code = {8'h00, `CMD_READ_ARRAY};
         endcase
      end
   endfunction

   // Register write strobe aimed at one word index
   function wr_hit;
      input       we;
      input [3:0] a;
      input [3:0] want;
      begin
         wr_hit = we && (a == want);
      end
   endfunction

   // Reset release and pin synchronisers
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_b <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rst_meta_b <= 1'b1;
         rst_sync_b <= rst_meta_b;
      end
   end

   // The part answers with no clock of ours, so every pin input takes two flops
   always @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         dq_meta <= 16'h0000;
         dq_sync <= 16'h0000;
         rb_meta <= 1'b0;
         rb_sync <= 1'b0;
      end else begin
         dq_meta <= dq_in;
         dq_sync <= dq_meta;
         rb_meta <= ready_busy_output;
         rb_sync <= rb_meta;
      end
   end

   flash_bus_cycle cycle (
      .clock      (clock),
      .rst_sync_b (rst_sync_b),
      .start      (start),
      .is_write   (is_write),
      .addr       (cyc_addr),
      .wdata      (cyc_data),
      .dq_sync    (dq_sync),
      .done       (cyc_done),
      .rdata      (cyc_rdata),
      .flash_addr (pin_addr),
      .dq_out     (pin_dq),
      .dq_oe_b    (pin_dq_oe_b),
      .ce_b       (pin_ce_b),
      .we_b       (pin_we_b),
      .oe_b       (pin_oe_b)
   );

   // Pins come straight from flops; one extra clock of delay is harmless on async pins
   always @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         flash_addr <= {`ADDR_W{1'b0}};
         dq_out <= 16'h0000;
         dq_oe_b <= 1'b1;
         ce_b <= 1'b1;
         we_b <= 1'b1;
         oe_b <= 1'b1;
         flash_reset_b <= 1'b0;
      end else begin
         flash_addr <= pin_addr;
         dq_out <= pin_dq;
         dq_oe_b <= pin_dq_oe_b;
         ce_b <= pin_ce_b;
         we_b <= pin_we_b;
         oe_b <= pin_oe_b;
         // Flash leaves reset with us, so its command latch starts in array read
         flash_reset_b <= 1'b1;
      end
   end

   always @* begin
      next_state = state;
      case (state)
         S_IDLE: next_state = state;
         S_SETUP: begin
            if (cyc_done)
               next_state = (op == `OP_CLEAR) ? S_WAIT : S_SECOND;
         end
         S_SECOND: begin
            if (cyc_done)
               next_state = S_WAIT;
         end
         S_WAIT: begin
            // Ready pin falls only after the confirm and the synchroniser may still show
            // it high here; polling bit 7 covers that case
            if (rb_sync || op == `OP_CLEAR)
               next_state = (op == `OP_CLEAR) ? S_IDLE : S_POLLC;
         end
         S_POLLC: begin
            if (cyc_done)
               next_state = S_POLLR;
         end
         S_POLLR: begin
            if (cyc_done && cyc_rdata[`SR_READY])
               next_state = array_after ? S_ARRAY : S_IDLE;
            else if (cyc_done)
               next_state = S_POLLR;
         end
         S_ARRAY: begin
            if (cyc_done)
               next_state = S_IDLE;
         end
         S_CLEAR: next_state = S_IDLE;
         default: next_state = S_IDLE;
      endcase
   end

   always @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         state <= S_IDLE;
         op <= 3'h0;
         alt <= 1'b0;
         array_after <= 1'b0;
         op_addr <= {`ADDR_W{1'b0}};
         op_data <= 16'h0000;
         last_status <= 8'h80;
         busy <= 1'b0;
         error <= 1'b0;
         start <= 1'b0;
         is_write <= 1'b0;
         cyc_addr <= {`ADDR_W{1'b0}};
         cyc_data <= 16'h0000;
      end else begin
         state <= next_state;
         start <= 1'b0;
         if (wr_hit(reg_write, reg_addr, `REG_ADDR))
            op_addr <= reg_wdata[`ADDR_W-1:0];
         if (wr_hit(reg_write, reg_addr, `REG_DATA))
            op_data <= reg_wdata[15:0];
         if (state == S_IDLE && wr_hit(reg_write, reg_addr, `REG_CTRL)
             && reg_wdata[2:0] != 3'h0) begin
            op <= reg_wdata[2:0];
            alt <= reg_wdata[`CTRL_ALT_BIT];
            array_after <= reg_wdata[`CTRL_ARRAY_BIT];
            busy <= 1'b1;
            state <= S_SETUP;
            start <= 1'b1;
            is_write <= 1'b1;
            cyc_addr <= op_addr;
            cyc_data <= {8'h00, setup_code(reg_wdata[2:0], reg_wdata[`CTRL_ALT_BIT])};
            // Clear-status wipes the software view of sticky errors too
            if (reg_wdata[2:0] == `OP_CLEAR) begin
               last_status <= 8'h80;
               error <= 1'b0;
            end
         end
         if (cyc_done && next_state == S_SECOND) begin
            start <= 1'b1;
            cyc_data <= second_code(op, op_data);
         end
         // No bus cycle runs in the wait state, so the status command is launched
         // on leaving it rather than on a done pulse
         if (state == S_WAIT && next_state == S_POLLC) begin
            start <= 1'b1;
            is_write <= 1'b1;
            cyc_data <= {8'h00, `CMD_READ_STATUS};
         end
         if (cyc_done && (state == S_POLLC || (state == S_POLLR && next_state == S_POLLR))) begin
            start <= 1'b1;
            is_write <= 1'b0;
         end
         if (cyc_done && state == S_POLLR && cyc_rdata[`SR_READY]) begin
            // Low bits only trusted once ready; reserved bit 0 dropped
            last_status <= cyc_rdata[7:0] & 8'hFE;
            // Deferred checking: error is reloaded from the sticky device error bits of each final status
            error <= |(cyc_rdata[7:0] & `SR_ERROR_MASK);
            if (array_after) begin
               start <= 1'b1;
               is_write <= 1'b1;
               cyc_data <= {8'h00, `CMD_READ_ARRAY};
            end
         end
         if (next_state == S_IDLE && state != S_IDLE)
            busy <= 1'b0;
      end
   end

   // Result decode: sequence error when bits 4 and 5 both set
   always @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b)
         reg_rdata <= 32'h00000000;
      else if (reg_read) begin
         case (reg_addr)
            `REG_CTRL:   reg_rdata <= {27'h0, array_after, alt, op};
            `REG_ADDR:   reg_rdata <= {{(32-`ADDR_W){1'b0}}, op_addr};
            `REG_DATA:   reg_rdata <= {16'h0000, op_data};
            `REG_STATUS: reg_rdata <= {29'h0, rb_sync, error, busy};
            `REG_RESULT: reg_rdata <= {18'h0,
                                       last_status[`SR_PROTECT],
                                       last_status[`SR_SUPPLY_LOW],
                                       last_status[`SR_ERASE_ERR] & ~last_status[`SR_PROG_ERR],
                                       last_status[`SR_PROG_ERR] & ~last_status[`SR_ERASE_ERR],
                                       last_status[`SR_ERASE_ERR] & last_status[`SR_PROG_ERR],
                                       // Bit 8 is spare and reads zero
                                       1'b0,
                                       last_status};
            default:     reg_rdata <= 32'h00000000;
         endcase
      end else
         reg_rdata <= 32'h00000000;
   end
endmodule // flash_program_erase_lock_sequencer

// [flash_sequencer_checker.sv]
// Checker for the sequencer's pin and register ports
`timescale 1ns/10ps
module seq_checker (
   input wire        clock,
   input wire        rst_b,
   input wire        reg_read,
   input wire [31:0] reg_rdata,
   input wire [20:0] flash_addr,
   input wire [15:0] dq_out,
   input wire        dq_oe_b,
   input wire        ce_b,
   input wire        we_b,
   input wire        oe_b,
   input wire        flash_reset_b
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   sequence we_pulse_s;
      !we_b [*3] ##1 we_b;
   endsequence
   // The host must have let go of the data lines while the part drives them
   sequence rd_pulse_s;
      (!oe_b && dq_oe_b) [*4] ##1 oe_b;
   endsequence
   we_pulse_a: assert property ($fell(we_b) |-> we_pulse_s)
      else $error("write strobe width wrong");
   we_setup_a: assert property ($fell(we_b) |-> !$past(ce_b))
      else $error("select not set up before write");
   we_hold_a: assert property ($rose(we_b) |-> !ce_b)
      else $error("select not held after write");
   wr_stable_a: assert property (!we_b && !$past(we_b) |-> $stable(dq_out) && $stable(flash_addr))
      else $error("write data moved under strobe");
   wr_drive_a: assert property (!we_b |-> !dq_oe_b && oe_b)
      else $error("data not driven during write");
   rd_pulse_a: assert property ($fell(oe_b) |-> rd_pulse_s)
      else $error("read strobe wrong");
   rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
      else $error("read data outside read slot");
   flash_rst_a: assert property (rst_b [*5] |-> flash_reset_b)
      else $error("flash reset held too long");
endmodule // seq_checker
bind flash_program_erase_lock_sequencer seq_checker seq_checker_i (.clock, .rst_b, .reg_read,
   .reg_rdata, .flash_addr, .dq_out, .dq_oe_b, .ce_b, .we_b, .oe_b, .flash_reset_b);

// [flash_device_model.sv]
// Behavioural flash part: command decode, status register and ready pin
`timescale 1ns/10ps
module flash_device_model #(
   parameter int BUSY_NS = 2000
) (
   input  wire logic [20:0] flash_addr,
   input  wire logic [15:0] dq_wire,
   input  wire logic        ce_b,
   input  wire logic        we_b,
   input  wire logic        oe_b,
   input  wire logic        flash_reset_b,
   input  wire logic [1:0]  fault,
   input  wire logic        perm_locked,
   input  wire logic        all_locked,
   output logic      [15:0] dq_drive,
   output logic             ready_pin = 1'b1,
   output logic      [7:0]  setup_seen,
   output logic      [15:0] conf_seen,
   output logic      [20:0] conf_addr,
   output logic             status_mode = 1'b0,
   output logic             polled = 1'b0
);
   logic [7:0]  sr = 8'h80;
   logic [7:0]  pend = 8'h00;
   logic [15:0] shown;
   event        op_go;
   // Fault 1 fails the operation, fault 2 reports a bad sequence, fault 3 a low supply
   function automatic logic [7:0] decode(input logic [7:0] s, input logic [7:0] c);
      if (fault == 2'h2) return 8'h30;
      if (fault == 2'h3) return 8'h18;
      case (s)
         8'h30: return (c != 8'hD0) ? 8'h30 : all_locked ? 8'h02 : {2'h0, fault[0], 5'h00};
         8'h60: case (c)
            8'h01: return perm_locked ? 8'h02 : {3'h0, fault[0], 4'h0};
            8'hF1: return {3'h0, fault[0], 4'h0};
            8'hD0: return perm_locked ? 8'h02 : {2'h0, fault[0], 5'h00};
            default: return 8'h30;
         endcase
         default: return {3'h0, fault[0], 4'h0};
      endcase
   endfunction
   always @(negedge flash_reset_b) begin
      sr = 8'h80;
      pend = 8'h00;
      status_mode = 1'b0;
   end
   // Commands written while busy are decoded at once; the busy timer runs apart
   always @(posedge we_b) begin
      if (!ce_b && flash_reset_b) begin
         if (pend != 8'h00) begin
            setup_seen = pend;
            conf_seen = dq_wire;
            conf_addr = flash_addr;
            polled = 1'b0;
            status_mode = 1'b1;
            sr[7] = 1'b0;
            ready_pin = 1'b0;
            pend = 8'h00;
            -> op_go;
         end else begin
            case (dq_wire[7:0])
               8'hFF: status_mode = 1'b0;
               8'h70: begin
                  status_mode = 1'b1;
                  polled = 1'b1;
               end
               8'h50: sr = 8'h80;
               8'h40, 8'h10, 8'hC0, 8'h60, 8'h30: pend = dq_wire[7:0];
               default: ;
            endcase
         end
      end
   end
   // Busy time in its own process so a status command still lands while busy
   always @(op_go) begin
      #(BUSY_NS);
      sr = sr | decode(setup_seen, conf_seen[7:0]) | 8'h80;
      ready_pin = 1'b1;
   end
   // Junk below the ready bit while busy; reserved bit reads high
   always @* begin
      shown = status_mode ? {8'h00, sr[7] ? {sr[7:1], 1'b1} : 8'h55} : ~conf_seen;
      dq_drive = (!oe_b && !ce_b) ? shown : ~shown;
   end
endmodule // flash_device_model

// [flash_program_erase_lock_sequencer_tb_top.sv]
// Self-checking bench for the flash program, erase and lock sequencer
`timescale 1ns/10ps
`include "flash_seq_regs.vh"
module flash_program_erase_lock_sequencer_tb_top;
   logic        clock = 1'b0, rst_b = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
   logic [3:0]  reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0, res;
   logic [1:0]  fault = 2'h0;
   logic        perm_locked = 1'b0, all_locked = 1'b0;
   wire  [31:0] reg_rdata;
   wire  [20:0] flash_addr, conf_addr;
   wire  [15:0] dq_out, dq_drive, dq_in, conf_seen;
   wire  [7:0]  setup_seen;
   wire         dq_oe_b, ce_b, we_b, oe_b, flash_reset_b, ready_pin, status_mode, polled;
   int          err_count = 0, checks = 0;
   always #20 clock = ~clock;
   assign dq_in = dq_oe_b ? dq_drive : dq_out;
   flash_program_erase_lock_sequencer flash_program_erase_lock_sequencer_i (.clock, .rst_b,
      .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .flash_addr, .dq_out, .dq_oe_b,
      .dq_in, .ce_b, .we_b, .oe_b, .flash_reset_b, .ready_busy_output(ready_pin));
   flash_device_model flash_device_model_i (.flash_addr, .dq_wire(dq_in), .ce_b, .we_b, .oe_b,
      .flash_reset_b, .fault, .perm_locked, .all_locked, .dq_drive, .ready_pin, .setup_seen,
      .conf_seen, .conf_addr, .status_mode, .polled);
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic run_op(input logic [4:0] c, input logic [15:0] d, output logic [31:0] r);
      logic [31:0] s;
      int n;
      wr(`REG_ADDR, 32'h001A5C3);
      wr(`REG_DATA, {16'h0, d});
      wr(`REG_CTRL, {27'h0, c});
      n = 0;
      do begin
         rd(`REG_STATUS, s);
         n++;
      end while (s[0] !== 1'b0 && n < 3000);
      if (s[0] !== 1'b0) begin
         err_count++;
         complete_run();
      end
      rd(`REG_RESULT, r);
   endtask
   function automatic logic [31:0] exp_res(input logic [7:0] s);
      return {18'h0, s[1], s[3], s[5] & ~s[4], s[4] & ~s[5], s[5] & s[4], 1'b0, s[7:1], 1'b0};
   endfunction
   task automatic op_check(input logic [4:0] c, input logic [15:0] d, input logic [7:0] su,
                           input logic [15:0] cf, input logic [7:0] sr);
      run_op(c, d, res);
      check(setup_seen, su);
      check(conf_seen, cf);
      check(conf_addr, 21'h1A5C3);
      check(polled, 1'b1);
      check(res, exp_res(sr));
   endtask
   task automatic clear_sr();
      run_op({2'h0, `OP_CLEAR}, 16'h0, res);
      rd(`REG_STATUS, res);
      check(res, 32'h4);
   endtask
   task automatic t_reset();
      rd(`REG_STATUS, res);
      check(res, 32'h4);
      check(status_mode, 1'b0);
      rd(4'hF, res);
      check(res, 32'h0);
      $display("reset test done");
   endtask
   task automatic t_program();
      op_check({2'h0, `OP_PROGRAM}, 16'h1234, 8'h40, 16'h1234, 8'h80);
      op_check({2'h1, `OP_PROGRAM}, 16'hA55A, 8'h10, 16'hA55A, 8'h80);
      fault = 2'h1;
      op_check({2'h0, `OP_PROGRAM}, 16'h0F0F, 8'h40, 16'h0F0F, 8'h90);
      fault = 2'h0;
      op_check({2'h0, `OP_PROGRAM}, 16'h0F0F, 8'h40, 16'h0F0F, 8'h90);
      clear_sr();
      op_check({2'h0, `OP_OTP}, 16'hC3C3, 8'hC0, 16'hC3C3, 8'h80);
      fault = 2'h3;
      op_check({2'h0, `OP_PROGRAM}, 16'h5A5A, 8'h40, 16'h5A5A, 8'h98);
      fault = 2'h0;
      rd(`REG_STATUS, res);
      check(res, 32'h6);
      clear_sr();
      $display("program test done");
   endtask
   task automatic t_erase();
      all_locked = 1'b1;
      op_check({2'h0, `OP_CHIP_ERASE}, 16'h1111, 8'h30, 16'h00D0, 8'h82);
      all_locked = 1'b0;
      clear_sr();
      fault = 2'h1;
      op_check({2'h0, `OP_CHIP_ERASE}, 16'h1111, 8'h30, 16'h00D0, 8'hA0);
      clear_sr();
      fault = 2'h2;
      op_check({2'h0, `OP_CHIP_ERASE}, 16'h1111, 8'h30, 16'h00D0, 8'hB0);
      fault = 2'h0;
      clear_sr();
      $display("erase test done");
   endtask
   task automatic t_lock();
      perm_locked = 1'b1;
      op_check({2'h0, `OP_LOCK_BLOCK}, 16'h2222, 8'h60, 16'h0001, 8'h82);
      op_check({2'h0, `OP_UNLOCK}, 16'h2222, 8'h60, 16'h00D0, 8'h82);
      perm_locked = 1'b0;
      clear_sr();
      fault = 2'h1;
      op_check({2'h0, `OP_LOCK_PERM}, 16'h2222, 8'h60, 16'h00F1, 8'h90);
      clear_sr();
      op_check({2'h0, `OP_UNLOCK}, 16'h2222, 8'h60, 16'h00D0, 8'hA0);
      fault = 2'h0;
      clear_sr();
      $display("lock test done");
   endtask
   task automatic t_tail();
      op_check({2'h2, `OP_PROGRAM}, 16'h4321, 8'h40, 16'h4321, 8'h80);
      check(status_mode, 1'b0);
      wr(`REG_CTRL, {27'h0, 2'h0, `OP_PROGRAM});
      repeat (20) @(posedge clock);
      rd(`REG_STATUS, res);
      check(res, 32'h1);
      op_check({2'h0, `OP_CHIP_ERASE}, 16'h4321, 8'h40, 16'h4321, 8'h80);
      $display("tail test done");
   endtask
   initial begin
      repeat (16) @(posedge clock);
      rst_b <= 1'b1;
      repeat (4) @(posedge clock);
      t_reset();
      t_program();
      t_erase();
      t_lock();
      t_tail();
      complete_run();
   end
endmodule // flash_program_erase_lock_sequencer_tb_top
